// ==== core/nsx_cfg.svh ====
// Purpose: Constants for the nibble swap / xor / direction-load execution block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit register index
// Notes: Definitions only
`ifndef NSX_CFG_SVH
`define NSX_CFG_SVH
`define NSX_OPC6_NIBBLE 6'h0e
`define NSX_OPC6_RXOR 6'h06
`define NSX_OPC6_LXOR 6'h3a
`define NSX_DIRLD_HI 11'h00c
`define NSX_DIR_IDX_LO 3'h5
`define NSX_DIR_IDX_HI 3'h7
`define NSX_IDX_PORTA 3'h5
`define NSX_IDX_PORTB 3'h6
`define NSX_IDX_PORTC 3'h7
`define NSX_DIR_RST 8'hff
`define NSX_ACC_RST 8'h00
`define NSX_ZERO_RST 1'b0
`define NSX_ZERO_BYTE 8'h00
`define NSX_FIDX_ZERO 7'h00
`define NSX_DIR_COUNT 3
`endif

// ==== core/nsx_pkg.sv ====
// Purpose: Types for the nibble swap / xor / direction-load execution block
// Assumes: Constants come from nsx_cfg.svh
// Notes: Structs carry grouped signals
package nsx_pkg;
   typedef enum logic [2:0] {
      NSX_OP_NONE,
      NSX_OP_NIBBLE,
      NSX_OP_LXOR,
      NSX_OP_RXOR,
      NSX_OP_DIRLD
   } nsx_op_t;

   typedef struct packed {
      logic we;
      logic [6:0] idx;
      logic [7:0] data;
   } nsx_fwr_t;

   typedef struct packed {
      logic we;
      logic [6:0] idx;
      logic [7:0] data;
   } nsx_dwr_t;
endpackage

// ==== core/nsx_dir_reg.sv ====
// Purpose: One pin direction register with legacy load and addressed access
// Assumes: Synchronous active-high reset; both write sources may fire in one cycle
// Notes: Legacy load wins when both writes land in one cycle
`timescale 1ns/1ps
`include "nsx_cfg.svh"
module nsx_dir_reg
   import nsx_pkg::*;
#(
   parameter logic [2:0] IDX = `NSX_IDX_PORTA
)
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_legacy_we,
   input wire logic [7:0] i_acc,
   input wire nsx_dwr_t i_bus_wr,
   output logic [7:0] o_dir
);
   logic [7:0] dir_q;
   logic [7:0] dir_d;

   always_comb
   begin
      dir_d = dir_q;
      if (i_bus_wr.we && i_bus_wr.idx == {4'h0, IDX})
      begin
         dir_d = i_bus_wr.data; // see RQ7
      end
      if (i_legacy_we)
      begin
         dir_d = i_acc; // see RQ6
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         dir_q <= `NSX_DIR_RST;
      end
      else
      begin
         dir_q <= dir_d;
      end
   end

   assign o_dir = dir_q;
endmodule // nsx_dir_reg

// ==== core/nsx_exec.sv ====
// Purpose: Executes nibble exchange, literal xor, register xor, direction load
// Assumes: One instruction per clock; file read data is combinational for i_instr
// Notes: All outputs registered except o_file_raddr; results visible to the next instruction
//
// Functional notes
// RQ1 - Nibble exchange puts low nibble of file register high, high nibble low.
// RQ2 - Nibble exchange targets accumulator or file by select bit; flags untouched.
// RQ3 - Literal xor replaces accumulator with accumulator xor literal; sets zero flag.
// RQ4 - Register xor computes accumulator xor file register; updates zero flag.
// RQ5 - Register xor result goes to accumulator or file by select bit.
// RQ6 - Direction load copies accumulator into direction register of port 5 to 7.
// RQ7 - Direction registers also readable and writable as addressed registers.
// RQ8 - Each instruction is one word and completes in one cycle.
`timescale 1ns/1ps
`include "nsx_cfg.svh"
module nsx_exec
   import nsx_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   input wire logic [7:0] i_file_rdata,
   input wire logic i_acc_load,
   input wire logic [7:0] i_acc_load_data,
   input wire logic i_zero_load,
   input wire logic i_zero_load_val,
   input wire nsx_dwr_t i_dir_bus_wr,
   input wire logic [2:0] i_dir_rd_idx,
   output logic [6:0] o_file_raddr,
   output nsx_fwr_t o_file_wr,
   output logic [7:0] o_acc,
   output logic o_zero,
   output logic [7:0] o_dir_a,
   output logic [7:0] o_dir_b,
   output logic [7:0] o_dir_c,
   output logic [7:0] o_dir_rdata,
   output nsx_op_t o_last_op
);
   logic [7:0] acc_q;
   logic [7:0] acc_d;
   logic zero_q;
   logic zero_d;
   nsx_fwr_t fwr_q;
   nsx_fwr_t fwr_d;
   nsx_op_t op_q;
   nsx_op_t op_d;
   logic [7:0] drd_q;
   logic [7:0] drd_d;
   nsx_op_t op;
   logic tgt_file;
   logic [6:0] fidx;
   logic [7:0] lit;
   logic [7:0] result;
   logic [`NSX_DIR_COUNT-1:0] legacy_we;
   logic [7:0] dir_val [`NSX_DIR_COUNT];

   assign tgt_file = i_instr[7];
   assign fidx = i_instr[6:0];
   assign lit = i_instr[7:0];
   // Left combinational: file data must answer within the same cycle
   assign o_file_raddr = fidx;

   // Decode
   always_comb
   begin
      op = NSX_OP_NONE;
      if (i_instr_valid)
      begin
         if (i_instr[13:8] == `NSX_OPC6_NIBBLE)
         begin
            op = NSX_OP_NIBBLE; // see RQ1
         end
         else if (i_instr[13:8] == `NSX_OPC6_RXOR)
         begin
            op = NSX_OP_RXOR; // see RQ4
         end
         else if (i_instr[13:8] == `NSX_OPC6_LXOR)
         begin
            op = NSX_OP_LXOR; // see RQ3
         end
         // Refused direction indices fall through and do nothing
         else if (i_instr[13:3] == `NSX_DIRLD_HI
            && i_instr[2:0] >= `NSX_DIR_IDX_LO && i_instr[2:0] <= `NSX_DIR_IDX_HI)
         begin
            op = NSX_OP_DIRLD; // see RQ6
         end
      end
   end

   // Execute; whole instruction settles in this one edge
   always_comb
   begin
      acc_d = acc_q;
      zero_d = zero_q;
      // Write pulse lasts one cycle unless a store is decoded
      fwr_d = '{we: 1'b0, idx: fidx, data: `NSX_ZERO_BYTE};
      op_d = op;
      result = `NSX_ZERO_BYTE;
      legacy_we = '0;
      // External loads first, so the block's own result wins
      if (i_zero_load)
      begin
         zero_d = i_zero_load_val;
      end
      if (i_acc_load)
      begin
         acc_d = i_acc_load_data;
      end
      case (op)
         NSX_OP_NIBBLE:
         begin
            result = {i_file_rdata[3:0], i_file_rdata[7:4]}; // see RQ1
            // Flags deliberately left alone
            if (tgt_file)
            begin
               fwr_d = '{we: 1'b1, idx: fidx, data: result}; // see RQ2
            end
            else
            begin
               acc_d = result; // see RQ2
            end
         end
         NSX_OP_LXOR:
         begin
            result = acc_q ^ lit; // see RQ3
            acc_d = result;
            zero_d = (result == `NSX_ZERO_BYTE); // see RQ3
         end
         NSX_OP_RXOR:
         begin
            result = acc_q ^ i_file_rdata; // see RQ4
            zero_d = (result == `NSX_ZERO_BYTE); // see RQ4
            if (tgt_file)
            begin
               fwr_d = '{we: 1'b1, idx: fidx, data: result}; // see RQ5
            end
            else
            begin
               acc_d = result; // see RQ5
            end
         end
         NSX_OP_DIRLD:
         begin
            // Index already checked to 5..7, so offset lands in 0..2
            legacy_we[2'(i_instr[2:0] - `NSX_DIR_IDX_LO)] = 1'b1; // see RQ6
         end
         default:
         begin
            // Unknown words write no result; last op records NSX_OP_NONE
            op_d = NSX_OP_NONE;
         end
      endcase
   end

   // One register per port; each decodes its own bus index
   genvar g;
   for (g = 0; g < `NSX_DIR_COUNT; g++)
   begin : g_dir
      nsx_dir_reg #(
         .IDX(3'(`NSX_IDX_PORTA + g))
      ) u_dir (
         .i_core_clk(i_core_clk),
         .i_sys_rst(i_sys_rst),
         .i_legacy_we(legacy_we[g]),
         .i_acc(acc_q),
         .i_bus_wr(i_dir_bus_wr),
         .o_dir(dir_val[g])
      );
   end

   // Addressed read port; out-of-range index reads zero
   always_comb
   begin
      case (i_dir_rd_idx)
         `NSX_IDX_PORTA: drd_d = dir_val[0]; // see RQ7
         `NSX_IDX_PORTB: drd_d = dir_val[1];
         `NSX_IDX_PORTC: drd_d = dir_val[2];
         default: drd_d = `NSX_ZERO_BYTE;
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         acc_q <= `NSX_ACC_RST;
         zero_q <= `NSX_ZERO_RST;
         fwr_q <= '{we: 1'b0, idx: `NSX_FIDX_ZERO, data: `NSX_ZERO_BYTE};
         op_q <= NSX_OP_NONE;
      end
      else
      begin
         acc_q <= acc_d; // see RQ8
         zero_q <= zero_d;
         fwr_q <= fwr_d;
         op_q <= op_d;
      end
   end

   // Read port kept apart so it never waits on the decode path
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         drd_q <= `NSX_ZERO_BYTE;
      end
      else
      begin
         drd_q <= drd_d; // see RQ7
      end
   end

   // Every output below comes straight from a flop
   assign o_acc = acc_q;
   assign o_zero = zero_q;
   assign o_file_wr = fwr_q;
   assign o_last_op = op_q;
   assign o_dir_rdata = drd_q;
   assign o_dir_a = dir_val[0];
   assign o_dir_b = dir_val[1];
   assign o_dir_c = dir_val[2];
endmodule // nsx_exec

// ==== tb/nsx_exec_props.sv ====
// Purpose: Port checks for nsx_exec
// Assumes: Sync active-high reset
// Notes: Bound after endmodule
`timescale 1ns/1ps
module nsx_exec_props
   import nsx_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   input wire logic [7:0] i_file_rdata,
   input wire logic [2:0] i_dir_rd_idx,
   input wire nsx_fwr_t o_file_wr,
   input wire logic [7:0] o_acc,
   input wire logic o_zero,
   input wire logic [7:0] o_dir_a,
   input wire logic [7:0] o_dir_b,
   input wire logic [7:0] o_dir_rdata,
   input wire nsx_op_t o_last_op
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   wire v = i_instr_valid;
   wire sw = v && i_instr[13:8] == 6'h0e;
   wire lx = v && i_instr[13:8] == 6'h3a;
   wire rx = v && i_instr[13:8] == 6'h06;
   wire [7:0] q = i_file_rdata;
   a_swap_acc: assert property (
      sw && !i_instr[7] |=> o_acc == {$past(q[3:0]), $past(q[7:4])})
      else $error("swap to acc wrong");
   a_swap_file: assert property (
      sw && i_instr[7] |=> o_file_wr.we && o_file_wr.idx == $past(i_instr[6:0])
         && o_file_wr.data == {$past(q[3:0]), $past(q[7:4])})
      else $error("swap to file wrong");
   a_lit_xor: assert property (
      lx |=> o_acc == ($past(o_acc) ^ $past(i_instr[7:0])) && o_zero == (o_acc == 8'h00))
      else $error("literal xor wrong");
   a_reg_xor_zero: assert property (
      rx |=> o_zero == (($past(o_acc) ^ $past(q)) == 8'h00))
      else $error("register xor zero wrong");
   a_reg_xor_dest: assert property (
      rx && i_instr[7] |=> o_file_wr.we && o_file_wr.data == ($past(o_acc) ^ $past(q))
         && o_file_wr.idx == $past(i_instr[6:0]))
      else $error("register xor store wrong");
   a_dir_load: assert property (
      v && i_instr == 14'h0066 |=> o_dir_b == $past(o_acc))
      else $error("direction load wrong");
   a_dir_read: assert property (
      i_dir_rd_idx == 3'h5 |=> o_dir_rdata == $past(o_dir_a))
      else $error("direction read wrong");
   a_write_pulse: assert property (
      o_file_wr.we |-> $past(v) && o_last_op != NSX_OP_NONE)
      else $error("file write without word");
endmodule // nsx_exec_props
bind nsx_exec nsx_exec_props u_props (.*);

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for nsx_exec
// Assumes: Inputs move on falling edges
// Notes: Keeps its own file and state model
`timescale 1ns/1ps
module tb
   import nsx_pkg::*;
;
   logic i_core_clk = 0, i_sys_rst = 1, i_instr_valid = 0, i_acc_load = 0, z = 0;
   logic i_zero_load = 0, i_zero_load_val = 0, o_zero;
   logic [13:0] i_instr = 0;
   logic [7:0] i_file_rdata, i_acc_load_data = 0, o_acc, o_dir_a, o_dir_b, o_dir_c;
   logic [7:0] o_dir_rdata, f[128], d[8], a = 0, r, t, e;
   logic [2:0] i_dir_rd_idx = 0;
   logic [6:0] o_file_raddr;
   nsx_dwr_t i_dir_bus_wr = '0;
   nsx_fwr_t o_file_wr, w;
   nsx_op_t o_last_op, op;
   int mismatches = 0, checks = 0, n = 0, seed = 32'hd78b685d;
   // Write-through, so a word right after a store sees it
   assign i_file_rdata = o_file_wr.we && o_file_wr.idx == o_file_raddr ?
      o_file_wr.data : f[o_file_raddr];
   nsx_exec DUT (.*);
   initial forever #2.5 i_core_clk = ~i_core_clk;
   task complete_run;
      if (mismatches == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string s, input logic [15:0] x, y);
      checks++;
      if (x !== y)
      begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", s, x, y);
      end
   endtask
   function automatic logic [7:0] exp_result(input int ty, input logic [7:0] acc, lit, fd);
      if (ty == 0)
         return {fd[3:0], fd[7:4]};
      return acc ^ (ty == 1 ? lit : fd);
   endfunction
   task go(input int ty, input logic [13:0] x);
      i_instr_valid = ty < 4;
      i_dir_rd_idx = x[13:11];
      e = x[13:11] > 4 ? d[x[13:11]] : 8'h00;
      // Side loads and bus writes also ride along with real words
      i_acc_load = x[10] && (ty == 4 || x[13]);
      i_acc_load_data = x[7:0];
      i_zero_load = x[9] && (ty == 4 || x[13]);
      i_zero_load_val = x[8];
      i_dir_bus_wr = '{x[7] && (ty > 2 || x[13]),
         ty == 3 ? {4'h0, x[2:0]} : 7'h05 + x[1:0], x[12:5]};
      case (ty)
         0: i_instr = {6'h0e, x[7:0]};
         1: i_instr = {6'h3a, x[11:10] != 0 ? x[7:0] : a};
         2: i_instr = {6'h06, x[7:0]};
         3: i_instr = {11'h00c, x[2:0]};
         default: i_instr = x;
      endcase
      #1;
      t = i_file_rdata;
      r = exp_result(ty, a, i_instr[7:0], t);
      w = '0;
      op = ty < 3 ? nsx_op_t'(ty + 1) : NSX_OP_NONE;
      if (i_dir_bus_wr.we && i_dir_bus_wr.idx > 4 && i_dir_bus_wr.idx < 8)
         d[i_dir_bus_wr.idx[2:0]] = i_dir_bus_wr.data;
      // Legacy load after the bus write: it wins on the same port
      if (ty == 3 && x[2:0] > 4)
      begin
         d[x[2:0]] = a;
         op = NSX_OP_DIRLD;
      end
      // Side loads before the block result, which overrides them
      if (i_acc_load)
         a = i_acc_load_data;
      if (i_zero_load)
         z = i_zero_load_val;
      if (ty != 1 && ty < 3 && i_instr[7])
         w = '{1'b1, i_instr[6:0], r};
      else if (ty < 3)
         a = r;
      if (ty == 1 || ty == 2)
         z = r == 8'h00;
      @(negedge i_core_clk);
      chk("acc", 16'(a), 16'(o_acc));
      chk("zero", 16'(z), 16'(o_zero));
      chk("fwr", w, o_file_wr.we ? o_file_wr : '0);
      chk("op", 16'(op), 16'(o_last_op));
      chk("dir", {d[5], d[6]}, {o_dir_a, o_dir_b});
      chk("dir_rd", {d[7], e}, {o_dir_c, o_dir_rdata});
   endtask
   // File store taken mid-cycle, away from the edge that launches it
   always @(negedge i_core_clk)
   begin
      if (o_file_wr.we)
         f[o_file_wr.idx] <= o_file_wr.data;
      n <= n + 1;
      if (n == 3000)
      begin
         mismatches++;
         complete_run;
      end
   end
   initial
   begin
      foreach (f[i]) f[i] = 8'($random(seed));
      foreach (d[i]) d[i] = 8'hff;
      f[5] = 8'ha5;
      repeat (5) @(negedge i_core_clk);
      i_sys_rst = 0;
      @(negedge i_core_clk);
      go(4, 14'h04b5);
      go(1, 14'h0caf);
      go(0, 14'h0085);
      go(0, 14'h0005);
      go(1, 14'h27ff);
      go(2, 14'h0085);
      go(1, 14'h0000);
      go(3, 14'h0006);
      go(3, 14'h0004);
      go(3, 14'h0007);
      go(3, 14'h2087);
      go(3, 14'h2805);
      repeat (400) go($unsigned($random(seed)) % 5, 14'($random(seed)));
      complete_run;
   end
endmodule // tb
